// *** core/lcw_pkg.sv ***
package lcw_pkg;

    // Symbol codes, 8-bit form y:x of Dx.y / Kx.y
    localparam logic [7:0] LCW_K28_5 = 8'hbc;  // Init comma
    localparam logic [7:0] LCW_K28_7 = 8'hfc;  // Plain comma
    localparam logic [7:0] LCW_D14_6 = 8'hce;  // Lane word identifier
    localparam logic [7:0] LCW_D17_1 = 8'h31;  // Identifier as seen inverted
    localparam logic [7:0] LCW_D31_3 = 8'h7f;  // Skip
    localparam logic [7:0] LCW_D15_6 = 8'hcf;  // Idle
    localparam logic [7:0] LCW_D6_2  = 8'h46;  // Handshake one
    localparam logic [7:0] LCW_D25_5 = 8'hb9;  // Handshake one inverted
    localparam logic [7:0] LCW_D6_5  = 8'ha6;  // Handshake two
    localparam logic [7:0] LCW_D25_2 = 8'h59;  // Handshake two inverted
    localparam logic [7:0] LCW_D24_1 = 8'h38;  // Handshake three
    localparam logic [7:0] LCW_D30_3 = 8'h7e;  // Standby notice
    localparam logic [7:0] LCW_D4_3  = 8'h64;  // Signal lost notice

    // Capability symbol layout
    localparam int         LCW_CAP_FLUSH_BIT  = 0;
    localparam int         LCW_CAP_START_BIT  = 1;
    localparam int         LCW_CAP_SCRAM_BIT  = 2;
    localparam logic [4:0] LCW_CAP_RSVD_VALUE = 5'h00;

    // Skip spacing
    localparam int          LCW_CNT_W    = 13;
    localparam logic [12:0] LCW_SKIP_MAX = 13'h1388;  // 5000 words
    localparam logic [12:0] LCW_SKIP_MIN = 13'h0001;

    // Four-symbol word, symbol 0 in the low byte and sent first
    typedef struct packed {
        logic [3:0]  k;     // Control flag per symbol
        logic [31:0] d;     // Symbol data
    } lcw_word_t;

    typedef struct packed {
        logic data_scrambled;
        logic lane_start;
        logic remote_flush;
    } lcw_cap_t;

    typedef enum logic [3:0] {
        LCW_NONE, LCW_DATA, LCW_SKIP, LCW_IDLE, LCW_HS1, LCW_HS2, LCW_HS3,
        LCW_STANDBY, LCW_NOSIG, LCW_HS1_INV, LCW_HS2_INV, LCW_BAD
    } lcw_kind_t;

    typedef enum logic {LCW_TX_ACTIVE, LCW_TX_STANDBY} lcw_txst_t;

endpackage

// *** core/lcw_word_gen.sv ***
`timescale 1ns/10ps
module lcw_word_gen (
    input  lcw_pkg::lcw_kind_t kind,      // Word to build
    input  lcw_pkg::lcw_cap_t  cap,       // Own capability flags
    input  lcw_pkg::lcw_word_t data,      // Retry layer word
    output lcw_pkg::lcw_word_t word       // Built word
);
    import lcw_pkg::*;

    // Comma low, identifier, then code symbol twice
    function automatic lcw_word_t lane_word(input logic [7:0] comma, input logic [7:0] code);
        lane_word.k = 4'h1;
        lane_word.d = {code, code, LCW_D14_6, comma};
    endfunction

    // Capability: reserved bits forced to zero
    function automatic logic [7:0] cap_sym(input lcw_cap_t c);
        cap_sym = {LCW_CAP_RSVD_VALUE, c.data_scrambled, c.lane_start,
                   c.remote_flush};
    endfunction

    // Only the upright forms exist here; inverted ones never leave this end
    always_comb begin
        unique case (kind)
            LCW_DATA:  word = data;
            LCW_SKIP:  word = lane_word(LCW_K28_7, LCW_D31_3);
            LCW_HS1:   word = lane_word(LCW_K28_5, LCW_D6_2);
            LCW_HS2:   word = lane_word(LCW_K28_5, LCW_D6_5);
            LCW_HS3:   word = '{k: 4'h1,
                                d: {cap_sym(cap), LCW_D24_1, LCW_D14_6, LCW_K28_5}};
            LCW_STANDBY: word = lane_word(LCW_K28_7, LCW_D30_3);
            LCW_NOSIG: word = lane_word(LCW_K28_7, LCW_D4_3);
            default:   word = lane_word(LCW_K28_7, LCW_D15_6);
        endcase
    end
endmodule // lcw_word_gen

// *** core/lcw_word_dec.sv ***
`timescale 1ns/10ps
module lcw_word_dec (
    input  lcw_pkg::lcw_word_t word,      // Received word
    output lcw_pkg::lcw_kind_t kind,      // Classified kind
    output lcw_pkg::lcw_cap_t  cap        // Capability of handshake three
);
    import lcw_pkg::*;

    // Lane word with repeated code symbol
    function automatic logic is_lane(input lcw_word_t w, input logic [7:0] comma,
                                     input logic [7:0] id, input logic [7:0] code);
        is_lane = (w.k == 4'h1) && (w.d[7:0] == comma) && (w.d[15:8] == id) &&
                  (w.d[23:16] == code) && (w.d[31:24] == code);
    endfunction

    // Reserved capability bits are simply not looked at
    assign cap = '{data_scrambled: word.d[24 + LCW_CAP_SCRAM_BIT],
                   lane_start:     word.d[24 + LCW_CAP_START_BIT],
                   remote_flush:   word.d[24 + LCW_CAP_FLUSH_BIT]};

    // Classification; lane-identified words that match nothing are bad
    always_comb begin
        if (is_lane(word, LCW_K28_7, LCW_D14_6, LCW_D31_3)) begin
            kind = LCW_SKIP;
        end else if (is_lane(word, LCW_K28_7, LCW_D14_6, LCW_D15_6)) begin
            kind = LCW_IDLE;
        end else if (is_lane(word, LCW_K28_5, LCW_D14_6, LCW_D6_2)) begin
            kind = LCW_HS1;
        end else if (is_lane(word, LCW_K28_5, LCW_D14_6, LCW_D6_5)) begin
            kind = LCW_HS2;
        end else if (word.k == 4'h1 && word.d[23:0] == {LCW_D24_1, LCW_D14_6, LCW_K28_5}) begin
            kind = LCW_HS3;
        end else if (is_lane(word, LCW_K28_7, LCW_D14_6, LCW_D30_3)) begin
            kind = LCW_STANDBY;
        end else if (is_lane(word, LCW_K28_7, LCW_D14_6, LCW_D4_3)) begin
            kind = LCW_NOSIG;
        end else if (is_lane(word, LCW_K28_5, LCW_D17_1, LCW_D25_5)) begin
            kind = LCW_HS1_INV;
        end else if (is_lane(word, LCW_K28_5, LCW_D17_1, LCW_D25_2)) begin
            kind = LCW_HS2_INV;
        end else if (word.k[0] && (word.d[15:8] == LCW_D14_6 || word.d[15:8] == LCW_D17_1)) begin
            kind = LCW_BAD;
        end else begin
            kind = LCW_DATA;
        end
    end
endmodule // lcw_word_dec

// *** core/lcw_codec.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Comma sits in the low symbol and goes out first.
// - Skip word is K28.7, D14.6, D31.3, D31.3.
// - One skip word after every N words, N at most 5000.
// - Idle word is K28.7, D14.6, D15.6, D15.6.
// - Once initialised, idle fills every slot not taken by a retry, skip, handshake or notice word.
// - Handshake one is K28.5, D14.6, D6.2, D6.2.
// - Receiver reads K28.5, D17.1, D25.5, D25.5 as inverted handshake one.
// - Handshake two is K28.5, D14.6, D6.5, D6.5.
// - Receiver reads K28.5, D17.1, D25.2, D25.2 as inverted handshake two.
// - Handshake three is K28.5, D14.6, D24.1, capability symbol.
// - Capability symbol states this end's own lane capabilities.
// - Standby word is K28.7, D14.6, D30.3, D30.3.
// - After sending standby, enter standby and disable the line driver.
// - Signal-lost word is K28.7, D14.6, D4.3, D4.3.
// - Send signal-lost word while own receiver has lost signal, unless standby is requested, being sent or in force.
// - Fourth symbol repeats third in all lane words but handshake three.
// - Receiver drops or repeats skip words to keep its elastic buffer safe.
// - Capability bit 0 flush, bit 1 manual start, bit 2 scrambled.
// - Capability bits 3 to 7 sent as zero, ignored on receipt.
// - Inverted handshake words are never transmitted by this end.
module lcw_codec (
    input  wire logic                  mclk,            // Lane word clock
    input  wire logic                  rst,             // Sync reset, active high
    input  wire logic                  lane_ready,      // Lane initialised
    input  lcw_pkg::lcw_kind_t         tx_init_req,     // Handshake word wanted
    input  lcw_pkg::lcw_cap_t          tx_cap,          // Own capability flags
    input  wire logic [12:0]           skip_interval,   // Words between skips
    input  wire logic                  standby_req,     // Go to standby
    input  wire logic                  standby_wake,    // Leave standby
    input  wire logic                  rx_signal_lost,  // Own receiver has no signal
    input  lcw_pkg::lcw_word_t         tx_data,         // Retry layer word
    input  wire logic                  tx_data_valid,   // Retry word present
    output logic                       tx_data_ready,   // Retry word taken
    output lcw_pkg::lcw_word_t         tx_word,         // Word to serialiser
    output lcw_pkg::lcw_kind_t         tx_kind,         // Kind of tx_word
    output logic                       tx_drive_en,     // Line driver enable
    input  lcw_pkg::lcw_word_t         rx_word_in,      // Word from deserialiser
    input  wire logic                  rx_word_in_valid, // Word present
    input  wire logic                  eb_near_full,    // Elastic buffer high
    input  wire logic                  eb_near_empty,   // Elastic buffer low
    output lcw_pkg::lcw_word_t         rx_word,         // Word to elastic buffer
    output logic                       rx_word_valid,   // Write strobe
    output logic                       rx_skip_repeat,  // Write the skip twice
    output lcw_pkg::lcw_kind_t         rx_kind,         // Kind of rx_word
    output lcw_pkg::lcw_cap_t          rx_cap,          // Far end capability
    output logic                       rx_cap_valid,    // Handshake three seen
    output logic                       rx_invert,       // Invert incoming bits
    output logic                       rx_bad_word      // Unknown lane word pulse
);
    import lcw_pkg::*;

    // Clamp the configured spacing into 1..5000
    function automatic logic [12:0] clamp_n(input logic [12:0] n);
        if (n > LCW_SKIP_MAX) begin
            clamp_n = LCW_SKIP_MAX;
        end else if (n < LCW_SKIP_MIN) begin
            clamp_n = LCW_SKIP_MIN;
        end else begin
            clamp_n = n;
        end
    endfunction

    lcw_word_t   tx_word_reg, tx_word_next, gen_word;
    lcw_kind_t   tx_kind_reg, tx_kind_next, sel_kind;
    lcw_txst_t   tx_st_reg, tx_st_next;
    logic        drive_reg, drive_next;
    logic [12:0] cnt_reg, cnt_next, skip_n;
    logic        skip_due;

    lcw_word_t   rx_word_reg, rx_word_next;
    logic        rx_valid_reg, rx_valid_next;
    logic        rx_rep_reg, rx_rep_next;
    lcw_kind_t   rx_kind_reg, rx_kind_next, dec_kind;
    lcw_cap_t    rx_cap_reg, rx_cap_next, dec_cap;
    logic        rx_capv_reg, rx_capv_next;
    logic        rx_inv_reg, rx_inv_next;
    logic        rx_bad_reg, rx_bad_next;

    lcw_word_gen u_gen (
        .kind (sel_kind),
        .cap  (tx_cap),
        .data (tx_data),
        .word (gen_word)
    );

    lcw_word_dec u_dec (
        .word (rx_word_in),
        .kind (dec_kind),
        .cap  (dec_cap)
    );

    assign skip_n   = clamp_n(skip_interval);
    assign skip_due = lane_ready && (cnt_reg >= skip_n);

    // Slot priority: standby, signal lost, handshake, skip, data, idle
    always_comb begin
        sel_kind      = LCW_IDLE;
        tx_data_ready = 1'b0;
        if (tx_st_reg == LCW_TX_STANDBY) begin
            sel_kind = LCW_IDLE;
        end else if (tx_kind_reg == LCW_STANDBY) begin
            sel_kind = LCW_IDLE;  // Driver goes off next edge, so no word taken
        end else if (standby_req) begin
            sel_kind = LCW_STANDBY;
        end else if (rx_signal_lost) begin
            sel_kind = LCW_NOSIG;
        end else if (tx_init_req == LCW_HS1 || tx_init_req == LCW_HS2 ||
                     tx_init_req == LCW_HS3) begin
            sel_kind = tx_init_req;
        end else if (skip_due) begin
            sel_kind = LCW_SKIP;
        end else if (lane_ready && tx_data_valid) begin
            sel_kind      = LCW_DATA;
            tx_data_ready = 1'b1;
        end else begin
            sel_kind = LCW_IDLE;
        end
    end

    // Transmit next state; standby holds the driver off until woken
    always_comb begin
        tx_word_next = gen_word;
        tx_kind_next = sel_kind;
        tx_st_next   = tx_st_reg;
        drive_next   = drive_reg;
        cnt_next     = cnt_reg;
        if (tx_st_reg == LCW_TX_STANDBY) begin
            cnt_next = 13'h0000;
            if (standby_wake) begin
                tx_st_next = LCW_TX_ACTIVE;
                drive_next = 1'b1;
            end
        end else begin
            if (tx_kind_reg == LCW_STANDBY) begin
                tx_st_next = LCW_TX_STANDBY;
                drive_next = 1'b0;
                tx_kind_next = LCW_IDLE;
            end
            if (sel_kind == LCW_SKIP) begin
                cnt_next = 13'h0000;
            end else if (cnt_reg < LCW_SKIP_MAX) begin
                cnt_next = cnt_reg + 13'h0001;
            end
        end
    end

    // Transmit registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_word_reg <= '{k: 4'h0, d: 32'h0000_0000};
            tx_kind_reg <= LCW_NONE;
            tx_st_reg   <= LCW_TX_ACTIVE;
            drive_reg   <= 1'b1;
            cnt_reg     <= 13'h0000;
        end else begin
            tx_word_reg <= tx_word_next;
            tx_kind_reg <= tx_kind_next;
            tx_st_reg   <= tx_st_next;
            drive_reg   <= drive_next;
            cnt_reg     <= cnt_next;
        end
    end

    // Receive next state; lane words other than skip are consumed here
    always_comb begin
        rx_word_next  = rx_word_in;
        rx_kind_next  = dec_kind;
        rx_valid_next = 1'b0;
        rx_rep_next   = 1'b0;
        rx_bad_next   = 1'b0;
        rx_cap_next   = rx_cap_reg;
        rx_capv_next  = rx_capv_reg && lane_ready;
        rx_inv_next   = rx_inv_reg;
        if (rx_word_in_valid) begin
            unique case (dec_kind)
                LCW_HS1_INV, LCW_HS2_INV: begin
                    rx_inv_next = ~rx_inv_reg;
                end
                LCW_SKIP: begin
                    rx_valid_next = !eb_near_full;
                    rx_rep_next   = !eb_near_full && eb_near_empty;
                end
                LCW_HS3: begin
                    rx_cap_next  = dec_cap;
                    rx_capv_next = 1'b1;
                end
                LCW_BAD: begin
                    rx_bad_next = 1'b1;
                end
                LCW_DATA: begin
                    rx_valid_next = 1'b1;
                end
                default: begin
                    rx_valid_next = 1'b0;
                end
            endcase
        end
    end

    // Receive registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_word_reg  <= '{k: 4'h0, d: 32'h0000_0000};
            rx_kind_reg  <= LCW_NONE;
            rx_valid_reg <= 1'b0;
            rx_rep_reg   <= 1'b0;
            rx_bad_reg   <= 1'b0;
            rx_cap_reg   <= '{data_scrambled: 1'b0, lane_start: 1'b0, remote_flush: 1'b0};
            rx_capv_reg  <= 1'b0;
            rx_inv_reg   <= 1'b0;
        end else begin
            rx_word_reg  <= rx_word_next;
            rx_kind_reg  <= rx_kind_next;
            rx_valid_reg <= rx_valid_next;
            rx_rep_reg   <= rx_rep_next;
            rx_bad_reg   <= rx_bad_next;
            rx_cap_reg   <= rx_cap_next;
            rx_capv_reg  <= rx_capv_next;
            rx_inv_reg   <= rx_inv_next;
        end
    end

    assign tx_word        = tx_word_reg;
    assign tx_kind        = tx_kind_reg;
    assign tx_drive_en    = drive_reg;
    assign rx_word        = rx_word_reg;
    assign rx_word_valid  = rx_valid_reg;
    assign rx_skip_repeat = rx_rep_reg;
    assign rx_kind        = rx_kind_reg;
    assign rx_cap         = rx_cap_reg;
    assign rx_cap_valid   = rx_capv_reg;
    assign rx_invert      = rx_inv_reg;
    assign rx_bad_word    = rx_bad_reg;

    // Checks on transmit and receive behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Transmit side
    a_comma_first: assert property (
        !(tx_kind_reg inside {LCW_DATA, LCW_NONE})
        |-> tx_word_reg.k == 4'h1 && tx_word_reg.d[7] && tx_word_reg.d[4:0] == 5'h1c)
        else $error("lane word without leading comma");
    a_dup_symbol: assert property (
        tx_kind_reg inside {LCW_SKIP, LCW_IDLE, LCW_HS1, LCW_HS2, LCW_STANDBY, LCW_NOSIG}
        |-> tx_word_reg.d[31:24] == tx_word_reg.d[23:16])
        else $error("fourth symbol differs from third");
    a_skip_spacing: assert property (cnt_reg <= LCW_SKIP_MAX)
        else $error("skip spacing above limit");
    a_skip_after: assert property (
        skip_due && tx_st_reg == LCW_TX_ACTIVE && tx_kind_reg != LCW_STANDBY && !standby_req
        && !rx_signal_lost && tx_init_req == LCW_NONE |=> tx_kind_reg == LCW_SKIP)
        else $error("due skip not sent");
    a_idle_fill: assert property (
        lane_ready && !tx_data_valid && !skip_due && !standby_req && !rx_signal_lost
        && tx_init_req == LCW_NONE && tx_st_reg == LCW_TX_ACTIVE
        |=> tx_kind_reg == LCW_IDLE && tx_word_reg.k == 4'h1
        && tx_word_reg.d == {LCW_D15_6, LCW_D15_6, LCW_D14_6, LCW_K28_7})
        else $error("empty slot not filled with idle");
    a_data_slot: assert property (
        tx_data_valid && tx_data_ready
        |=> tx_kind_reg == LCW_DATA && tx_word_reg == $past(tx_data))
        else $error("taken retry word not sent");
    a_standby_drive: assert property (
        tx_kind_reg == LCW_STANDBY && tx_st_reg == LCW_TX_ACTIVE
        |=> !tx_drive_en && tx_st_reg == LCW_TX_STANDBY && tx_kind_reg == LCW_IDLE)
        else $error("driver on after standby word");
    a_standby_refuse: assert property (
        tx_st_reg == LCW_TX_STANDBY || tx_kind_reg == LCW_STANDBY |-> !tx_data_ready)
        else $error("retry word taken around standby");
    a_los_sent: assert property (
        rx_signal_lost && !standby_req && tx_st_reg == LCW_TX_ACTIVE
        && tx_kind_reg != LCW_STANDBY
        |=> tx_kind_reg == LCW_NOSIG && tx_word_reg.d[23:16] == LCW_D4_3)
        else $error("signal-lost word not sent");
    a_never_inverse: assert property (
        tx_kind_reg != LCW_DATA |-> tx_word_reg.d[15:8] != LCW_D17_1)
        else $error("inverted identifier transmitted");
    a_cap_reserved: assert property (
        tx_kind_reg == LCW_HS3 |-> tx_word_reg.d[31:27] == LCW_CAP_RSVD_VALUE)
        else $error("reserved capability bits set");

    // Receive side
    a_invert_flip: assert property (
        rx_word_in_valid && dec_kind inside {LCW_HS1_INV, LCW_HS2_INV}
        |=> rx_invert != $past(rx_invert))
        else $error("polarity not flipped");
    a_skip_drop: assert property (
        rx_word_in_valid && dec_kind == LCW_SKIP && eb_near_full
        |=> !rx_word_valid && !rx_skip_repeat)
        else $error("skip kept while buffer high");
    a_skip_keep: assert property (
        rx_word_in_valid && dec_kind == LCW_SKIP && !eb_near_full
        |=> rx_word_valid && rx_skip_repeat == $past(eb_near_empty))
        else $error("skip not written as the buffer needs");
    a_cap_latch: assert property (
        rx_word_in_valid && dec_kind == LCW_HS3 && lane_ready
        |=> rx_cap_valid && rx_cap == $past(dec_cap))
        else $error("far capability not latched");
    a_bad_flag: assert property (
        rx_word_in_valid && dec_kind == LCW_BAD |=> rx_bad_word ##1
        (!rx_bad_word || ($past(rx_word_in_valid) && $past(dec_kind) == LCW_BAD)))
        else $error("unknown lane word not flagged");

    c_skip_sent: cover property (tx_kind_reg == LCW_SKIP);
    c_standby:   cover property (tx_st_reg == LCW_TX_STANDBY ##1 tx_drive_en);
    c_invert:    cover property (rx_invert);
    c_repeat:    cover property (rx_skip_repeat);
    c_bad_word:  cover property (rx_bad_word);
endmodule // lcw_codec

// *** test/lcw_far_end.sv ***
`timescale 1ns/10ps
// Far lane end: builds lane words on request and releases the line otherwise
module lcw_far_end (
    input  wire logic          mclk,  // Word clock
    input  lcw_pkg::lcw_kind_t kind,  // Word to send, LCW_NONE releases
    input  lcw_pkg::lcw_cap_t  cap,   // Own capability flags
    input  wire logic [4:0]    rsvd,  // Reserved capability bits
    output lcw_pkg::lcw_word_t word,  // Word to the receiver
    output logic               valid  // Word present
);
    import lcw_pkg::*;
    lcw_word_t last_reg = '0;
    // Released line shows the inverse of the last word, so stale data never matches
    always_comb begin
        valid  = 1'b1;
        word.k = 4'h1;
        case (kind)
            LCW_SKIP:   word.d = {LCW_D31_3, LCW_D31_3, LCW_D14_6, LCW_K28_7};
            LCW_IDLE:   word.d = {LCW_D15_6, LCW_D15_6, LCW_D14_6, LCW_K28_7};
            LCW_HS1:     word.d = {LCW_D6_2, LCW_D6_2, LCW_D14_6, LCW_K28_5};
            LCW_HS2:     word.d = {LCW_D6_5, LCW_D6_5, LCW_D14_6, LCW_K28_5};
            LCW_HS3:     word.d = {rsvd, cap, LCW_D24_1, LCW_D14_6, LCW_K28_5};
            LCW_STANDBY: word.d = {LCW_D30_3, LCW_D30_3, LCW_D14_6, LCW_K28_7};
            LCW_NOSIG:   word.d = {LCW_D4_3, LCW_D4_3, LCW_D14_6, LCW_K28_7};
            LCW_HS1_INV: word.d = {LCW_D25_5, LCW_D25_5, LCW_D17_1, LCW_K28_5};
            LCW_HS2_INV: word.d = {LCW_D25_2, LCW_D25_2, LCW_D17_1, LCW_K28_5};
            LCW_BAD:    word.d = {8'h00, 8'h00, LCW_D14_6, LCW_K28_7};
            default: begin
                valid = 1'b0;
                word  = ~last_reg;
            end
        endcase
    end
    // Remember the last word sent
    always_ff @(posedge mclk) if (valid) last_reg <= word;
endmodule  // lcw_far_end

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import lcw_pkg::*;
    logic       mclk, rst, lane_ready, standby_req, standby_wake, rx_signal_lost;
    logic       tx_data_valid, tx_data_ready, tx_drive_en, rx_in_valid, eb_near_full;
    logic       eb_near_empty, rx_word_valid, rx_skip_repeat, rx_cap_valid, rx_invert;
    logic       rx_bad_word;
    logic [12:0] skip_interval;
    logic [4:0] frsvd;
    lcw_kind_t  tx_init_req, tx_kind, rx_kind, fk;
    lcw_cap_t   tx_cap, rx_cap, fcap;
    lcw_word_t  tx_data, tx_word, rx_in, rx_word;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cyc = 0;

    lcw_codec uut (.mclk(mclk), .rst(rst), .lane_ready(lane_ready), .tx_init_req(tx_init_req),
        .tx_cap(tx_cap), .skip_interval(skip_interval), .standby_req(standby_req),
        .standby_wake(standby_wake), .rx_signal_lost(rx_signal_lost), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready), .tx_word(tx_word),
        .tx_kind(tx_kind), .tx_drive_en(tx_drive_en), .rx_word_in(rx_in),
        .rx_word_in_valid(rx_in_valid), .eb_near_full(eb_near_full),
        .eb_near_empty(eb_near_empty), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .rx_skip_repeat(rx_skip_repeat), .rx_kind(rx_kind), .rx_cap(rx_cap),
        .rx_cap_valid(rx_cap_valid), .rx_invert(rx_invert), .rx_bad_word(rx_bad_word));
    lcw_far_end far (.mclk(mclk), .kind(fk), .cap(fcap), .rsvd(frsvd), .word(rx_in),
        .valid(rx_in_valid));

    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc >= 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic lcw_word_t lw(input logic [7:0] c0, input logic [7:0] c2,
                                     input logic [7:0] c3);
        return '{k: 4'h1, d: {c3, c2, LCW_D14_6, c0}};
    endfunction
    task automatic step();
        @(negedge mclk);
    endtask

    // Handshake words, both capability patterns so every flag is set once
    task automatic t_handshake();
        lcw_kind_t  ks[4] = '{LCW_HS1, LCW_HS2, LCW_HS3, LCW_HS3};
        logic [7:0] cs[4] = '{LCW_D6_2, LCW_D6_5, LCW_D24_1, LCW_D24_1};
        logic [2:0] cp[4] = '{3'b000, 3'b000, 3'b011, 3'b100};
        for (int i = 0; i < 4; i++) begin
            tx_init_req = ks[i];
            tx_cap      = lcw_cap_t'(cp[i]);
            step();
            chk("hs word", tx_word, lw(LCW_K28_5, cs[i], (i < 2) ? cs[i] : {5'h00, cp[i]}));
        end
        tx_init_req = LCW_NONE;
    endtask

    // Idle fills empty slots, a retry word is taken and sent
    task automatic t_idle_data();
        lane_ready = 1'b1;
        repeat (2) step();
        chk("idle word", tx_word, lw(LCW_K28_7, LCW_D15_6, LCW_D15_6));
        tx_data       = '{k: 4'h0, d: 32'h1234abcd};
        tx_data_valid = 1'b1;
        #1 chk("ready", 36'(tx_data_ready), 36'h1);
        step();
        tx_data_valid = 1'b0;
        chk("data word", tx_word, tx_data);
    endtask

    // Skip spacing at N=3 and at the clamped minimum
    task automatic t_skip();
        logic [12:0] iv[2] = '{13'h0003, 13'h0000};
        int          n[2] = '{3, 1};
        for (int s = 0; s < 2; s++) begin
            skip_interval = iv[s];
            for (int w = 0; w < 12 && tx_kind !== LCW_SKIP; w++) step();
            for (int r = 0; r < 2; r++) begin
                for (int j = 0; j < n[s]; j++) begin
                    step();
                    chk("non skip", 36'(tx_kind), 36'(LCW_IDLE));
                end
                step();
                chk("skip word", tx_word, lw(LCW_K28_7, LCW_D31_3, LCW_D31_3));
            end
        end
        skip_interval = 13'h1388;
    endtask

    // Standby word, driver off, then wake
    task automatic t_standby();
        standby_req = 1'b1;
        step();
        standby_req   = 1'b0;
        tx_data_valid = 1'b1;
        chk("powerdown_notice_code word", tx_word, lw(LCW_K28_7, LCW_D30_3, LCW_D30_3));
        #1 chk("powerdown_notice_code ready", 36'(tx_data_ready), 36'h0);
        step();
        chk("drv off", 36'({tx_drive_en, tx_kind}), 36'(LCW_IDLE));
        tx_data_valid = 1'b0;
        standby_wake  = 1'b1;
        step();
        standby_wake = 1'b0;
        chk("drv on", 36'(tx_drive_en), 36'h1);
    endtask

    // Signal lost notice in every slot, retry word refused
    task automatic t_los();
        rx_signal_lost = 1'b1;
        tx_data_valid  = 1'b1;
        repeat (3) begin
            step();
            chk("los word", tx_word, lw(LCW_K28_7, LCW_D4_3, LCW_D4_3));
            chk("los ready", 36'(tx_data_ready), 36'h0);
        end
        rx_signal_lost = 1'b0;
        tx_data_valid  = 1'b0;
    endtask

    task automatic rx_send(input lcw_kind_t k);
        fk = k;
        step();
        fk = LCW_NONE;
    endtask
    // Receive: elastic buffer handling, polarity, capability, unknown word
    task automatic t_rx();
        lcw_kind_t ck[4] = '{LCW_HS1, LCW_HS2, LCW_STANDBY, LCW_NOSIG};
        eb_near_empty = 1'b1;
        rx_send(LCW_SKIP);
        chk("skip rpt", {rx_word_valid, rx_skip_repeat}, 36'h3);
        chk("skip rx", rx_word, lw(LCW_K28_7, LCW_D31_3, LCW_D31_3));
        eb_near_empty = 1'b0;
        eb_near_full  = 1'b1;
        rx_send(LCW_SKIP);
        chk("skip drop", 36'(rx_word_valid), 36'h0);
        eb_near_full = 1'b0;
        rx_send(LCW_HS1_INV);
        chk("inv one", {rx_invert, rx_word_valid}, 36'h2);
        rx_send(LCW_HS2_INV);
        chk("inv two", 36'(rx_invert), 36'h0);
        // Words consumed here: decoded kind shown, nothing written
        foreach (ck[i]) begin
            rx_send(ck[i]);
            chk("rx consumed", 36'({rx_word_valid, rx_kind}), 36'(ck[i]));
        end
        fcap  = lcw_cap_t'(3'b101);
        frsvd = 5'h1f;
        rx_send(LCW_HS3);
        chk("rx cap", {rx_cap_valid, rx_cap}, 36'hd);
        rx_send(LCW_BAD);
        chk("bad word", 36'(rx_bad_word), 36'h1);
        rx_send(LCW_IDLE);
        chk("idle rx", {rx_bad_word, rx_word_valid, rx_kind}, 36'(LCW_IDLE));
    endtask

    initial begin
        rst = 1'b1;  lane_ready = 1'b0;  standby_req = 1'b0;  standby_wake = 1'b0;
        rx_signal_lost = 1'b0;  tx_data_valid = 1'b0;  eb_near_full = 1'b0;
        eb_near_empty = 1'b0;  skip_interval = 13'h1388;  tx_init_req = LCW_NONE;
        tx_cap = '0;  tx_data = '0;  fk = LCW_NONE;  fcap = '0;  frsvd = 5'h00;
        repeat (12) step();
        rst = 1'b0;
        chk("rst kind", 36'(tx_kind), 36'(LCW_NONE));
        t_handshake();
        t_idle_data();
        t_skip();
        t_standby();
        t_los();
        t_rx();
        tally_and_finish();
    end
endmodule  // tb_top
